// ==== bench/request_source.sv ====
`timescale 1ns/1ps
// peripheral model raising the two request levels
module request_source (
  // clock
  input  wire logic core_clk,
  // commands from the bench
  input  wire logic want_maskable,
  input  wire logic want_nonmaskable,
  // request lines
  output logic      maskable_request,
  output logic      nonmaskable_request
);
  // requests held as levels until withdrawn
  always_ff @(posedge core_clk) begin
    maskable_request    <= want_maskable;
    nonmaskable_request <= want_nonmaskable;
  end
endmodule // request_source

// ==== bench/tb.sv ====
`timescale 1ns/1ps
// testbench: random boundaries and requests against a behavioural model
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %0t: output mismatch", $time); end end
module tb;
  logic                         core_clk;
  logic                         reset;
  irq_enable_pkg::step_type     step;
  logic                         want_m;
  logic                         want_n;
  logic                         maskable_request;
  logic                         nonmaskable_request;
  irq_enable_pkg::decision_type decision;
  irq_enable_pkg::decision_type exp_dec;
  irq_enable_pkg::decision_type exp_now;
  irq_enable_pkg::decision_type exp_q[$];
  logic                         mask_enable_live;
  logic                         mask_enable_saved;
  logic                         exp_live;
  logic                         exp_saved;
  logic                         started;
  int                           defer;
  int                           old_defer;
  int                           num_errors;
  int                           tests_run;
  int                           cycles;

  interrupt_enable_flags u_interrupt_enable_flags (.core_clk(core_clk), .reset(reset), .step(step),
    .maskable_request(maskable_request), .nonmaskable_request(nonmaskable_request),
    .decision(decision), .mask_enable_live(mask_enable_live), .mask_enable_saved(mask_enable_saved));
  request_source u_request_source (.core_clk(core_clk), .want_maskable(want_m),
    .want_nonmaskable(want_n), .maskable_request(maskable_request),
    .nonmaskable_request(nonmaskable_request));

  // clock
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // reference model, evaluated on the inputs seen at each edge
  always @(posedge core_clk) begin
    started = 1'b1;
    exp_dec = '0;
    if (reset) begin
      exp_live = 1'b0;
      exp_saved = 1'b0;
      defer = 0;
    end else if (step.boundary) begin
      old_defer = defer;
      defer = 0;
      if (nonmaskable_request) begin
        exp_dec.take_nonmaskable = 1'b1;
        exp_live = 1'b0;
      end else if (maskable_request && exp_live && old_defer == 0) begin
        exp_dec.take_maskable = 1'b1;
        exp_live = 1'b0;
        exp_saved = 1'b0;
      end else begin
        case (step.op)
          irq_enable_pkg::op_enable_interrupts: begin
            exp_live = 1'b1;
            exp_saved = 1'b1;
            defer = 1;
          end
          irq_enable_pkg::op_disable_interrupts: begin
            exp_live = 1'b0;
            exp_saved = 1'b0;
          end
          irq_enable_pkg::op_return_from_nonmaskable: exp_live = exp_saved;
          irq_enable_pkg::op_load_acc_from_vector_base,
          irq_enable_pkg::op_load_acc_from_refresh: begin
            exp_dec.parity_load = 1'b1;
            exp_dec.parity_value = exp_saved;
          end
          default: ;
        endcase
      end
    end
    exp_q.push_back(exp_dec);
  end

  // compare every cycle where outputs have settled
  always @(negedge core_clk) begin
    if (started && exp_q.size() != 0) begin
      exp_now = exp_q.pop_front();
      `CHK(decision.take_nonmaskable, exp_now.take_nonmaskable)
      `CHK(decision.take_maskable, exp_now.take_maskable)
      `CHK(decision.parity_load, exp_now.parity_load)
      if (exp_now.parity_load) `CHK(decision.parity_value, exp_now.parity_value)
      `CHK(mask_enable_live, exp_live)
      `CHK(mask_enable_saved, exp_saved)
    end
  end

  // closing report
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  // stimulus
  initial begin
    started = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    reset = 1'b1;
    step = '0;
    want_m = 1'b0;
    want_n = 1'b0;
    void'($urandom(32'h09C6));
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4000) begin
      @(posedge core_clk);
      step.boundary <= 1'($urandom_range(0, 1));
      step.op <= irq_enable_pkg::op_type'($urandom_range(0, 5));
      want_m <= 1'($urandom_range(0, 1));
      want_n <= ($urandom_range(0, 7) == 0);
      reset <= ($urandom_range(0, 199) == 0);
    end
    print_verdict();
  end
endmodule // tb

// ==== design/boundary_flag.sv ====
`timescale 1ns/1ps
// single registered request flag, sampled only at instruction boundaries
module boundary_flag (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // control
  input  wire logic sample,
  input  wire logic level,
  // result
  output logic      flag
);

  logic flag_reg;
  logic flag_next;

  // next value: load on boundary
  always_comb begin
    flag_next = sample ? level : flag_reg;
  end

  // register stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_reg <= irq_enable_pkg::flag_reset_value;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule // boundary_flag

// ==== design/interrupt_enable_flags.sv ====
`timescale 1ns/1ps
// interrupt enable flags: live and saved mask flip-flops and acceptance gating
// What this block does
// - a nonmaskable request present at an instruction boundary is always accepted, with no setting able to block it.
// - a maskable request is refused while the live mask flag is clear.
// - reset clears both the live and the saved mask flags.
// - enable sets both flags and disable clears both.
// - after enable, a maskable request waits until the next instruction has completed.
// - accepting a maskable interrupt clears both flags.
// - accepting a nonmaskable interrupt clears the live flag and keeps the saved flag.
// - both accumulator loads copy the saved flag into parity and leave both flags alone.
// - return from nonmaskable copies the saved flag into the live flag.
module interrupt_enable_flags (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // sequencer side
  input  wire irq_enable_pkg::step_type     step,
  // peripheral requests
  input  wire logic                         maskable_request,
  input  wire logic                         nonmaskable_request,
  // decisions and visible state
  output irq_enable_pkg::decision_type      decision,
  output logic                              mask_enable_live,
  output logic                              mask_enable_saved
);

  logic                         live_reg;
  logic                         live_next;
  logic                         saved_reg;
  logic                         saved_next;
  logic [1:0]                   defer_reg;
  logic [1:0]                   defer_next;
  irq_enable_pkg::decision_type decision_reg;
  irq_enable_pkg::decision_type decision_next;
  logic                         nmi_seen;
  logic                         int_seen;

  // request capture at boundaries
  boundary_flag nmi_sample (
    .core_clk (core_clk),
    .reset    (reset),
    .sample   (step.boundary),
    .level    (nonmaskable_request),
    .flag     (nmi_seen)
  );

  boundary_flag int_sample (
    .core_clk (core_clk),
    .reset    (reset),
    .sample   (step.boundary),
    .level    (maskable_request),
    .flag     (int_seen)
  );

  // next state of flags, deferral and decisions
  always_comb begin
    live_next     = live_reg;
    saved_next    = saved_reg;
    defer_next    = defer_reg;
    decision_next = '0;
    if (step.boundary) begin
      // acceptance uses the flags as they stand at this boundary
      if (nonmaskable_request) begin
        decision_next.take_nonmaskable = 1'b1;
        live_next = 1'b0;
      end else if (maskable_request && live_reg && defer_reg == 2'h0) begin
        decision_next.take_maskable = 1'b1;
        live_next  = 1'b0;
        saved_next = 1'b0;
      end else begin
        case (step.op)
          irq_enable_pkg::op_enable_interrupts: begin
            live_next  = 1'b1;
            saved_next = 1'b1;
            defer_next = irq_enable_pkg::defer_after_enable;
          end
          irq_enable_pkg::op_disable_interrupts: begin
            live_next  = 1'b0;
            saved_next = 1'b0;
          end
          irq_enable_pkg::op_return_from_nonmaskable: begin
            live_next = saved_reg;
          end
          irq_enable_pkg::op_load_acc_from_vector_base,
          irq_enable_pkg::op_load_acc_from_refresh: begin
            decision_next.parity_load  = 1'b1;
            decision_next.parity_value = saved_reg;
          end
          default: begin
          end
        endcase
      end
      // deferral counts down by one completed instruction
      if (step.op != irq_enable_pkg::op_enable_interrupts && defer_reg != 2'h0) begin
        defer_next = defer_reg - 2'h1;
      end
    end
  end

  // register stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      live_reg     <= irq_enable_pkg::flag_reset_value;
      saved_reg    <= irq_enable_pkg::flag_reset_value;
      defer_reg    <= irq_enable_pkg::defer_reset_value;
      decision_reg <= '0;
    end else begin
      live_reg     <= live_next;
      saved_reg    <= saved_next;
      defer_reg    <= defer_next;
      decision_reg <= decision_next;
    end
  end

  assign decision          = decision_reg;
  assign mask_enable_live  = live_reg;
  assign mask_enable_saved = saved_reg;

  // helper terms for the checks; the reset edge is kept out of antecedents, the flags clear there
  logic int_ready; // maskable request would win at this boundary if no nonmaskable request is present
  logic op_runs;   // boundary whose operation really executes
  assign int_ready = maskable_request && live_reg && (defer_reg == 2'h0);
  assign op_runs   = step.boundary && !nonmaskable_request && !int_ready;

  // step shapes
  sequence s_enable_step;
    !reset && op_runs && step.op == irq_enable_pkg::op_enable_interrupts;
  endsequence

  sequence s_next_boundary_int;
    step.boundary && maskable_request && !nonmaskable_request;
  endsequence

  sequence s_disable_step;
    !reset && op_runs && step.op == irq_enable_pkg::op_disable_interrupts;
  endsequence

  sequence s_nmi_step;
    !reset && step.boundary && nonmaskable_request;
  endsequence

  sequence s_int_step;
    !reset && step.boundary && !nonmaskable_request && int_ready;
  endsequence

  sequence s_load_step;
    !reset && op_runs && (step.op == irq_enable_pkg::op_load_acc_from_vector_base
      || step.op == irq_enable_pkg::op_load_acc_from_refresh);
  endsequence

  a_nmi_always_taken: assert property (@(posedge core_clk) disable iff (reset)
    s_nmi_step |=> decision.take_nonmaskable && !mask_enable_live)
    else $error("nonmaskable request not taken");

  a_mask_refuses: assert property (@(posedge core_clk) disable iff (reset)
    !mask_enable_live |=> !decision.take_maskable)
    else $error("maskable taken while live flag clear");

  a_reset_clears: assert property (@(posedge core_clk)
    reset |=> !mask_enable_live && !mask_enable_saved && decision == '0)
    else $error("reset left flags set");

  a_enable_sets: assert property (@(posedge core_clk) disable iff (reset)
    s_enable_step |=> mask_enable_live && mask_enable_saved)
    else $error("enable did not set both flags");

  a_enable_defers: assert property (@(posedge core_clk) disable iff (reset)
    s_enable_step ##1 s_next_boundary_int |=> !decision.take_maskable)
    else $error("maskable taken right after enable");

  a_int_clears: assert property (@(posedge core_clk) disable iff (reset)
    decision.take_maskable |-> !mask_enable_live && !mask_enable_saved)
    else $error("maskable acceptance left flags set");

  a_nmi_keeps_saved: assert property (@(posedge core_clk) disable iff (reset)
    s_nmi_step |=> mask_enable_saved == $past(saved_reg))
    else $error("nonmaskable acceptance changed saved flag");

  a_parity_copy: assert property (@(posedge core_clk) disable iff (reset)
    decision.parity_load |-> decision.parity_value == $past(saved_reg)
      && mask_enable_saved == $past(saved_reg) && mask_enable_live == $past(live_reg))
    else $error("parity copy wrong or flags changed");

  a_return_restores: assert property (@(posedge core_clk) disable iff (reset)
    !reset && op_runs && step.op == irq_enable_pkg::op_return_from_nonmaskable
      |=> mask_enable_live == $past(saved_reg))
    else $error("return did not restore live flag");

  a_boundary_only: assert property (@(posedge core_clk) disable iff (reset)
    !reset && !step.boundary |=> decision == '0 && $stable(mask_enable_live) && $stable(mask_enable_saved))
    else $error("action outside instruction boundary");

  a_disable_clears: assert property (@(posedge core_clk) disable iff (reset)
    s_disable_step |=> !mask_enable_live && !mask_enable_saved)
    else $error("disable did not clear both flags");

  a_defer_gap: assert property (@(posedge core_clk) disable iff (reset)
    s_enable_step ##1 !step.boundary ##1 s_next_boundary_int |=> !decision.take_maskable)
    else $error("maskable taken before the instruction after enable");

  a_int_taken: assert property (@(posedge core_clk) disable iff (reset)
    s_int_step |=> decision.take_maskable && !mask_enable_live && !mask_enable_saved)
    else $error("ready maskable request not taken");

  a_nmi_excludes: assert property (@(posedge core_clk) disable iff (reset)
    decision.take_nonmaskable |-> !decision.take_maskable && !decision.parity_load)
    else $error("nonmaskable acceptance shared its boundary");

  a_load_parity: assert property (@(posedge core_clk) disable iff (reset)
    s_load_step |=> decision.parity_load && decision.parity_value == $past(saved_reg))
    else $error("accumulator load gave no parity copy");

  // the capture stages follow the request levels at boundaries only
  a_capture_level: assert property (@(posedge core_clk) disable iff (reset)
    !reset && step.boundary |=> nmi_seen == $past(nonmaskable_request) && int_seen == $past(maskable_request))
    else $error("request level not captured at boundary");

  a_capture_holds: assert property (@(posedge core_clk) disable iff (reset)
    !reset && !step.boundary |=> $stable(nmi_seen) && $stable(int_seen))
    else $error("request capture moved between boundaries");

endmodule // interrupt_enable_flags

// ==== design/irq_enable_pkg.sv ====
// package: operation codes, carrier structs and constants for the interrupt enable flags
package irq_enable_pkg;

  // decoded operation, one per instruction boundary
  typedef enum logic [2:0] {
    op_none,
    op_enable_interrupts,
    op_disable_interrupts,
    op_return_from_nonmaskable,
    op_load_acc_from_vector_base,
    op_load_acc_from_refresh
  } op_type;

  // what the sequencer reports at an instruction boundary
  typedef struct packed {
    logic   boundary;
    op_type op;
  } step_type;

  // what the block tells the sequencer
  typedef struct packed {
    logic take_nonmaskable;
    logic take_maskable;
    logic parity_load;
    logic parity_value;
  } decision_type;

  localparam logic       flag_reset_value = 1'b0;
  localparam logic [1:0] defer_reset_value = 2'h0;
  localparam logic [1:0] defer_after_enable = 2'h1;

endpackage
